/* src/fpmsc_ctrl.sv */
// Serial-flash power-mode, status and page-size command block
`timescale 1ns/100ps
module fpmsc_ctrl #(
   parameter int NV_PROG_CYC = fpmsc_pkg::T_EP_CYC,
   parameter int UEXIT_CYC   = fpmsc_pkg::T_XUDPD_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire logic                  sck,
   input  wire logic                  cs_n,
   input  wire logic                  mosi,
   output logic                       miso_o,
   output logic                       miso_oe,
   input  wire logic                  array_busy,
   input  wire fpmsc_pkg::fpmsc_opres_t op_res,
   input  wire logic                  cmp_done,
   input  wire logic                  cmp_mismatch,
   input  wire logic                  protect_on,
   input  wire logic                  nv_page256,
   output logic                       page256,
   output logic                       nv_write,
   output logic                       standby,
   output logic                       deep_pd,
   output logic                       ultra_pd,
   output logic                       buffer_lost
);
   import fpmsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Link domain: byte assembly on rising serial clock

   logic [6:0]    shreg;
   logic [2:0]    bit_cnt;
   logic [2:0]    byte_cnt;
   fpmsc_cmd_t    cmd;
   logic          stat_on;
   logic [3:0]    out_idx;
   logic [15:0]   st_meta;
   logic [15:0]   st_link;
   logic          pd_meta;
   logic          pd_link;
   logic          cmd_tog;
   logic          pd_level;
   logic [15:0]   status_q;

   wire           link_rst_n = rst_n & ~cs_n;
   wire  [7:0]    rx_byte    = {shreg, mosi};
   wire           byte_end   = (bit_cnt == BIT_LAST);
   wire           first_edge = (bit_cnt == 3'h0) && (byte_cnt == 3'h0);

   // Shift register and counters, cleared by deselect
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         shreg    <= 7'h00;
         bit_cnt  <= 3'h0;
         byte_cnt <= 3'h0;
      end else begin
         shreg   <= rx_byte[6:0];
         bit_cnt <= bit_cnt + 3'h1;
         if (byte_end && byte_cnt != BYTE_SAT) begin
            byte_cnt <= byte_cnt + 3'h1;
         end
      end
   end

   // Next command after a whole byte
   function automatic fpmsc_cmd_t cmd_step(input fpmsc_cmd_t c,
                                           input logic [2:0]  n,
                                           input logic [7:0]  b);
      fpmsc_cmd_t r;
      r = c;
      unique case (n)
         3'h0: begin
            unique case (b)
               OP_DEEP_PD:  r = FPMSC_CMD_DEEP;
               OP_RESUME:   r = FPMSC_CMD_RESUME;
               OP_ULTRA_PD: r = FPMSC_CMD_ULTRA;
               OP_CFG_B0:   r = FPMSC_CMD_CFG_A;
               default:     r = FPMSC_CMD_NONE;
            endcase
         end
         3'h1: r = (c == FPMSC_CMD_CFG_A && b == OP_CFG_B1) ? FPMSC_CMD_CFG_B
                   : (c == FPMSC_CMD_CFG_A ? FPMSC_CMD_NONE : c);
         3'h2: r = (c == FPMSC_CMD_CFG_B && b == OP_CFG_B2) ? FPMSC_CMD_CFG_B
                   : (c == FPMSC_CMD_CFG_B ? FPMSC_CMD_NONE : c);
         3'h3: begin
            if (c == FPMSC_CMD_CFG_B) begin
               if (b == OP_CFG_P256) begin
                  r = FPMSC_CMD_P256;
               end else if (b == OP_CFG_P264) begin
                  r = FPMSC_CMD_P264;
               end else begin
                  r = FPMSC_CMD_NONE;
               end
            end
         end
         default: r = c;
      endcase
      return r;
   endfunction

   // Command latch survives deselect so the clock domain can read it
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         cmd <= FPMSC_CMD_NONE;
      end else if (first_edge) begin
         cmd <= FPMSC_CMD_NONE;
      end else if (byte_end) begin
         cmd <= cmd_step(cmd, byte_cnt, rx_byte);
      end
   end

   // Toggles once per frame that delivered a whole opcode byte; a bare select
   // pulse leaves it alone, so a stale command is never applied again
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         cmd_tog <= 1'b0;
      end else if (byte_end && byte_cnt == 3'h0) begin
         cmd_tog <= ~cmd_tog;
      end
   end

   // Status flags and power-down level brought into the link domain
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         st_meta <= 16'h0000;
         st_link <= 16'h0000;
         pd_meta <= 1'b0;
         pd_link <= 1'b0;
      end else begin
         st_meta <= status_q;
         st_link <= st_meta;
         pd_meta <= pd_level;
         pd_link <= pd_meta;
      end
   end

   // Status read starts after opcode unless powered down
   always_ff @(posedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         stat_on <= 1'b0;
      end else if (byte_end && byte_cnt == 3'h0) begin
         stat_on <= (rx_byte == OP_STATUS) && !pd_link;
      end
   end

   // Status bits leave on the falling edge, both bytes wrapping
   always_ff @(negedge sck or negedge link_rst_n) begin
      if (!link_rst_n) begin
         miso_o  <= 1'b0;
         miso_oe <= 1'b0;
         out_idx <= 4'h0;
      end else if (stat_on) begin
         miso_o  <= st_link[4'hf - out_idx];
         miso_oe <= 1'b1;
         out_idx <= out_idx + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock domain: frame edges, power state and status flags

   fpmsc_state_t  state;
   fpmsc_state_t  next_state;
   logic          cs_meta;
   logic          cs_sync;
   logic          cs_prev;
   logic          frame_ok;
   logic [CNT_W-1:0] timer;
   logic          pend256;
   logic          boot;
   logic          comp_q;
   logic          fault_q;
   logic          cmd_used;
   fpmsc_status_t status_s;

   wire frame_fall = cs_prev & ~cs_sync;
   wire frame_rise = cs_sync & ~cs_prev;
   wire nv_busy    = (state == FPMSC_ST_NVPROG);
   wire ready      = ~array_busy & ~nv_busy;
   wire timer_end  = (timer == '0);
   // Link words cmd and cmd_tog are settled long before the synchronised rise
   // that reads them, so they are taken as quasi-static levels here
   wire judge      = frame_rise && frame_ok && (cmd_tog != cmd_used);
   wire cfg_cmd    = (cmd == FPMSC_CMD_P256) || (cmd == FPMSC_CMD_P264);

   // Chip select passes two flops before any use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_prev <= 1'b1;
      end else if (ce) begin
         cs_meta <= cs_n;
         cs_sync <= cs_meta;
         cs_prev <= cs_sync;
      end
   end

   // A frame counts only if it began outside ultra-deep and its exit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_ok <= 1'b0;
      end else if (ce && frame_fall) begin
         frame_ok <= (state != FPMSC_ST_ULTRA) && (state != FPMSC_ST_UEXIT);
      end
   end

   // Toggle value of the last frame seen ending; a frame with no new byte is not judged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_used <= 1'b0;
      end else if (ce && frame_rise) begin
         cmd_used <= cmd_tog;
      end
   end

   // Next power state, judged at chip-select rise
   always_comb begin
      next_state = state;
      unique case (state)
         FPMSC_ST_IDLE: begin
            if (judge && ready && cmd == FPMSC_CMD_DEEP) begin
               next_state = FPMSC_ST_DEEP;
            end else if (judge && ready && cmd == FPMSC_CMD_ULTRA) begin
               next_state = FPMSC_ST_ULTRA;
            end else if (judge && !array_busy && cfg_cmd) begin
               next_state = FPMSC_ST_NVPROG;
            end
         end
         FPMSC_ST_NVPROG: begin
            if (timer_end) begin
               next_state = FPMSC_ST_IDLE;
            end
         end
         FPMSC_ST_DEEP: begin
            if (judge && cmd == FPMSC_CMD_RESUME) begin
               next_state = FPMSC_ST_IDLE;
            end
         end
         FPMSC_ST_ULTRA: begin
            if (frame_rise) begin
               next_state = FPMSC_ST_UEXIT;
            end
         end
         FPMSC_ST_UEXIT: begin
            if (timer_end) begin
               next_state = FPMSC_ST_IDLE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= FPMSC_ST_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Countdown for the nonvolatile program and the ultra-deep exit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer <= '0;
      end else if (ce) begin
         if (state != FPMSC_ST_NVPROG && next_state == FPMSC_ST_NVPROG) begin
            timer <= CNT_W'(NV_PROG_CYC - 1);
         end else if (state != FPMSC_ST_UEXIT && next_state == FPMSC_ST_UEXIT) begin
            timer <= CNT_W'(UEXIT_CYC - 1);
         end else if (!timer_end) begin
            timer <= timer - 1'b1;
         end
      end
   end

   // Page size: loaded from the nonvolatile cell after reset, applied at completion
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot    <= 1'b1;
         page256 <= PAGE256_RST;
         pend256 <= PAGE256_RST;
      end else if (ce) begin
         boot <= 1'b0;
         if (boot) begin
            page256 <= nv_page256;
         end else if (state == FPMSC_ST_IDLE && next_state == FPMSC_ST_NVPROG) begin
            pend256 <= (cmd == FPMSC_CMD_P256);
         end else if (nv_busy && timer_end) begin
            page256 <= pend256;
         end
      end
   end

   // Compare result and program/erase fault flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         comp_q  <= COMP_RST;
         fault_q <= FAULT_RST;
      end else if (ce) begin
         if (cmp_done) begin
            comp_q <= cmp_mismatch;
         end
         if (op_res.done || op_res.abort) begin
            fault_q <= op_res.fault && !op_res.abort;
         end
      end
   end

   // Status word assembled from live state
   always_comb begin
      status_s.ready1  = ready;
      status_s.comp    = comp_q;
      status_s.density = DENSITY_CODE;
      status_s.protect = protect_on;
      status_s.page256 = page256;
      status_s.ready2  = ready;
      status_s.res6    = 1'b0;
      status_s.fault   = fault_q;
      status_s.res_lo  = 5'h00;
   end

   // Registered copies handed to the link domain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= 16'h0000;
         pd_level <= 1'b0;
      end else if (ce) begin
         status_q <= status_s;
         pd_level <= (next_state == FPMSC_ST_DEEP) || (next_state == FPMSC_ST_ULTRA)
                     || (next_state == FPMSC_ST_UEXIT);
      end
   end

   // Mode outputs and one-cycle pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         standby     <= 1'b0;
         deep_pd     <= 1'b0;
         ultra_pd    <= 1'b0;
         buffer_lost <= 1'b0;
         nv_write    <= 1'b0;
      end else if (ce) begin
         standby     <= (state == FPMSC_ST_IDLE) && cs_sync && !array_busy;
         deep_pd     <= (state == FPMSC_ST_DEEP);
         ultra_pd    <= (state == FPMSC_ST_ULTRA);
         buffer_lost <= (state == FPMSC_ST_IDLE) && (next_state == FPMSC_ST_ULTRA);
         nv_write    <= nv_busy && timer_end;
      end
   end

endmodule

/* src/fpmsc_pkg.sv */
// Constants, types and status layout for the flash power-mode and status controller
package fpmsc_pkg;

   // Opcodes, shifted most-significant bit first
   localparam logic [7:0] OP_DEEP_PD   = 8'hb9;
   localparam logic [7:0] OP_RESUME    = 8'hab;
   localparam logic [7:0] OP_ULTRA_PD  = 8'h79;
   localparam logic [7:0] OP_STATUS    = 8'hd7;
   localparam logic [7:0] OP_CFG_B0    = 8'h3d;
   localparam logic [7:0] OP_CFG_B1    = 8'h2a;
   localparam logic [7:0] OP_CFG_B2    = 8'h80;
   localparam logic [7:0] OP_CFG_P256  = 8'ha6;
   localparam logic [7:0] OP_CFG_P264  = 8'ha7;

   // Legacy density code; the value is arbitrary
   localparam logic [3:0] DENSITY_CODE = 4'h9;

   // Reset values
   localparam logic       PAGE256_RST  = 1'b1;
   localparam logic       FAULT_RST    = 1'b0;
   localparam logic       COMP_RST     = 1'b0;

   // Bit and byte counters of the link, and the width of the clock-domain countdown timer
   localparam logic [2:0] BIT_LAST     = 3'h7;
   localparam logic [2:0] BYTE_SAT     = 3'h4;
   localparam int         CNT_W        = 20;

   // Self-timed durations in nanoseconds, and the clock period
   localparam int         CLK_PERIOD_NS = 40;
   localparam int         T_EP_NS       = 25000000;
   localparam int         T_XUDPD_NS    = 100000;
   localparam int         T_EP_CYC      = (T_EP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         T_XUDPD_CYC   = (T_XUDPD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Command decoded on the link, judged at chip-select rise
   typedef enum logic [2:0] {
      FPMSC_CMD_NONE,
      FPMSC_CMD_DEEP,
      FPMSC_CMD_RESUME,
      FPMSC_CMD_ULTRA,
      FPMSC_CMD_CFG_A,
      FPMSC_CMD_CFG_B,
      FPMSC_CMD_P256,
      FPMSC_CMD_P264
   } fpmsc_cmd_t;

   // Power and self-timed state
   typedef enum logic [2:0] {
      FPMSC_ST_IDLE,
      FPMSC_ST_NVPROG,
      FPMSC_ST_DEEP,
      FPMSC_ST_ULTRA,
      FPMSC_ST_UEXIT
   } fpmsc_state_t;

   // Two-byte status word, byte one first
   typedef struct packed {
      logic       ready1;
      logic       comp;
      logic [3:0] density;
      logic       protect;
      logic       page256;
      logic       ready2;
      logic       res6;
      logic       fault;
      logic [4:0] res_lo;
   } fpmsc_status_t;

   // Result of an array operation from the array sequencer
   typedef struct packed {
      logic done;
      logic abort;
      logic fault;
   } fpmsc_opres_t;

endpackage

/* sim/fpmsc_ctrl_checker.sv */
// Port-level assertions for the power-mode and status controller
`timescale 1ns/100ps
module fpmsc_ctrl_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic miso_oe,
   input wire logic array_busy,
   input wire logic page256,
   input wire logic nv_write,
   input wire logic standby,
   input wire logic deep_pd,
   input wire logic ultra_pd,
   input wire logic buffer_lost
);
   logic [3:0] cs_hi_cnt;

   // Clock cycles with chip select high, saturating so the judge delay is long past
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_hi_cnt <= 4'h0;
      end else begin
         cs_hi_cnt <= cs_n ? ((cs_hi_cnt == 4'hf) ? cs_hi_cnt : cs_hi_cnt + 4'h1) : 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Host has left the link deselected
   sequence s_deselected;
      cs_n [*4];
   endsequence

   // Deep mode with no frame pending judgement
   sequence s_quiet_deep;
      deep_pd && (cs_hi_cnt >= 4'h6);
   endsequence

   // Awake while the array engine is busy
   sequence s_awake_busy;
      array_busy && !deep_pd && !ultra_pd;
   endsequence

   // Page size may move only with the nv program pulse or out of reset
   sequence s_page_cause;
      nv_write || $past(nv_write) || !$past(rst_n) || !$past(rst_n, 2);
   endsequence

   AST_OE_IDLE: assert property (s_deselected |-> !miso_oe)
      else $error("output driven while deselected");
   AST_MODE_EXCL: assert property ($onehot0({standby, deep_pd, ultra_pd}))
      else $error("more than one power mode");
   AST_SEL_NOSTBY: assert property (!cs_n [*4] |-> !standby)
      else $error("standby while selected");
   AST_BUSY_NOSTBY: assert property (array_busy [*2] |-> !standby)
      else $error("standby while busy");
   AST_PD_BUSY: assert property (s_awake_busy |=> !deep_pd && !ultra_pd)
      else $error("power-down entered while busy");
   AST_DEEP_STAY: assert property (s_quiet_deep |=> deep_pd)
      else $error("deep mode left without a frame");
   AST_LOST_PULSE: assert property (buffer_lost |=> !buffer_lost)
      else $error("buffer lost pulse too long");
   AST_LOST_ULTRA: assert property (buffer_lost |-> ##[0:1] ultra_pd)
      else $error("buffer lost without ultra-deep");
   AST_NVWR_PULSE: assert property (nv_write |=> !nv_write)
      else $error("nv write pulse too long");
   AST_PAGE_CHG: assert property ($changed(page256) |-> s_page_cause)
      else $error("page size changed without nv program");
endmodule

/* sim/fpmsc_host_model.sv */
// Host SPI master model, mode 0, link clock only inside frames
`timescale 1ns/100ps
module fpmsc_host_model (
   output logic     sck,
   output logic     cs_n,
   output logic     mosi,
   input wire logic miso_o,
   input wire logic miso_oe
);
   // Link idles with clock low and chip select high
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // Shift nb bits of d, then clock nrd bits back; 160 ns link period
   task automatic frame(input logic [31:0] d, input int nb, input int nrd,
                        output logic [15:0] rx, output logic oe);
      rx = 16'h0000;
      oe = 1'b0;
      #13 cs_n = 1'b0;
      for (int i = 0; i < nb + nrd; i++) begin
         mosi = (i < nb) ? d[31-i] : ~mosi;
         #80 sck = 1'b1;
         oe |= miso_oe;
         // An undriven data line reads as the inverse of the last value
         if (i >= nb) rx = {rx[14:0], miso_oe ? miso_o : ~miso_o};
         #80 sck = 1'b0;
      end
      #80 cs_n = 1'b1;
      mosi = ~mosi;
      #400;
   endtask
endmodule

/* sim/fpmsc_ctrl_tb.sv */
// Self-checking bench for the power-mode and status controller
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin error_cnt++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, s); end end
module fpmsc_ctrl_tb;
   import fpmsc_pkg::*;
   localparam int NV_CYC = 400;
   localparam int UX_CYC = 60;
   logic         clk, rst_n, ce, sck, cs_n, mosi, miso_o, miso_oe, array_busy;
   logic         cmp_done, cmp_mismatch, protect_on, nv_page256, page256, nv_write;
   logic         standby, deep_pd, ultra_pd, buffer_lost, oe, lost_seen;
   logic         exp_rdy, exp_cmp, exp_prot, exp_pg, exp_flt;
   logic [15:0]  rx;
   fpmsc_opres_t op_res;
   int           error_cnt = 0;
   int           n_compared = 0;

   fpmsc_ctrl #(.NV_PROG_CYC(NV_CYC), .UEXIT_CYC(UX_CYC)) fpmsc_ctrl_inst (.clk(clk),
      .rst_n(rst_n), .ce(ce), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o),
      .miso_oe(miso_oe), .array_busy(array_busy), .op_res(op_res), .cmp_done(cmp_done),
      .cmp_mismatch(cmp_mismatch), .protect_on(protect_on), .nv_page256(nv_page256),
      .page256(page256), .nv_write(nv_write), .standby(standby), .deep_pd(deep_pd),
      .ultra_pd(ultra_pd), .buffer_lost(buffer_lost));
   fpmsc_host_model fpmsc_host_model_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi),
      .miso_o(miso_o), .miso_oe(miso_oe));

   // System clock and pulse catcher
   always #20 clk = ~clk;
   always @(posedge clk) if (buffer_lost === 1'b1) lost_seen <= 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic xf(input logic [31:0] d, input int nb, input int nrd);
      fpmsc_host_model_inst.frame(d, nb, nrd, rx, oe);
      tick(1);
   endtask

   // Read the status word and compare with the expected flags
   task automatic chk_status(input string nm);
      logic [7:0] exp_b1;
      logic [7:0] exp_b2;
      exp_b1 = {exp_rdy, exp_cmp, DENSITY_CODE, exp_prot, exp_pg};
      exp_b2 = {exp_rdy, 1'b0, exp_flt, 5'h00};
      xf({OP_STATUS, 24'h0}, 8, 16);
      `CHK(nm, {exp_b1, exp_b2}, rx)
   endtask

   // Reset release: page size loaded from the nonvolatile cell, status at defaults
   task automatic t_reset(input logic nv);
      nv_page256 = nv;
      rst_n = 1'b0;
      tick(4);
      rst_n = 1'b1;
      tick(6);
      {exp_rdy, exp_cmp, exp_prot, exp_pg, exp_flt} = {3'b100, nv, 1'b0};
      `CHK("reset page", nv, page256)
      `CHK("reset standby", 1'b1, standby)
      chk_status("reset");
      $display("test reset done");
   endtask

   task automatic t_flags;
      cmp_mismatch = 1'b1;
      cmp_done = 1'b1;
      protect_on = 1'b1;
      op_res = '{done: 1'b1, abort: 1'b0, fault: 1'b1};
      tick(1);
      cmp_done = 1'b0;
      op_res = '0;
      {exp_cmp, exp_prot, exp_flt} = 3'b111;
      tick(4);
      chk_status("flags set");
      op_res = '{done: 1'b0, abort: 1'b1, fault: 1'b1};
      cmp_mismatch = 1'b0;
      cmp_done = 1'b1;
      array_busy = 1'b1;
      tick(1);
      op_res = '0;
      cmp_done = 1'b0;
      {exp_cmp, exp_flt, exp_rdy} = 3'b000;
      tick(4);
      chk_status("abort busy");
      `CHK("busy standby", 1'b0, standby)
      array_busy = 1'b0;
      protect_on = 1'b0;
      {exp_rdy, exp_prot} = 2'b10;
      tick(4);
      chk_status("flags clear");
      $display("test flags done");
   endtask

   task automatic t_ignore;
      xf({OP_CFG_B0, OP_CFG_B1, OP_CFG_B2, 8'h00}, 24, 0);
      chk_status("short cfg");
      xf({OP_DEEP_PD, 24'h0}, 7, 0);
      `CHK("short deep", 3'b100, {standby, deep_pd, ultra_pd})
      xf({OP_ULTRA_PD, 24'h0}, 7, 0);
      `CHK("short ultra", 3'b100, {standby, deep_pd, ultra_pd})
      array_busy = 1'b1;
      xf({OP_DEEP_PD, 24'h0}, 8, 0);
      xf({OP_ULTRA_PD, 24'h0}, 8, 0);
      `CHK("busy pd", 3'b000, {standby, deep_pd, ultra_pd})
      array_busy = 1'b0;
      xf(32'h0, 0, 0);
      `CHK("bare select", 3'b100, {standby, deep_pd, ultra_pd})
      $display("test ignore done");
   endtask

   // Page-size change: busy during the nv program, new size at completion
   task automatic t_cfg(input logic [7:0] last, input logic pg);
      int n;
      n = 0;
      xf({OP_CFG_B0, OP_CFG_B1, OP_CFG_B2, last}, 32, 0);
      exp_rdy = 1'b0;
      chk_status("cfg busy");
      while (nv_write !== 1'b1 && n < 2 * NV_CYC) begin
         tick(1);
         n++;
      end
      `CHK("nv write", 1'b1, nv_write)
      tick(2);
      {exp_rdy, exp_pg} = {1'b1, pg};
      `CHK("page size", pg, page256)
      chk_status("cfg done");
      $display("test cfg done");
   endtask

   task automatic t_deep;
      xf({OP_DEEP_PD, 8'h5a, 16'h0}, 16, 0);
      `CHK("deep in", 3'b010, {standby, deep_pd, ultra_pd})
      xf({OP_STATUS, 24'h0}, 8, 16);
      `CHK("deep status", 1'b0, oe)
      xf({OP_RESUME, 24'h0}, 6, 0);
      `CHK("short resume", 3'b010, {standby, deep_pd, ultra_pd})
      xf({OP_RESUME, 8'h00, 16'h0}, 16, 0);
      `CHK("resume", 3'b100, {standby, deep_pd, ultra_pd})
      $display("test deep done");
   endtask

   task automatic t_ultra;
      xf({OP_ULTRA_PD, 24'h0}, 8, 0);
      `CHK("ultra in", 4'b0011, {standby, deep_pd, ultra_pd, lost_seen})
      xf({OP_STATUS, 24'h0}, 8, 16);
      `CHK("ultra status", 1'b0, oe)
      xf({OP_STATUS, 24'h0}, 8, 16);
      `CHK("exit status", 1'b0, oe)
      tick(2 * UX_CYC);
      `CHK("ultra out", 3'b100, {standby, deep_pd, ultra_pd})
      chk_status("after exit");
      $display("test ultra done");
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {clk, ce, array_busy, cmp_done, cmp_mismatch, protect_on} = 6'b010000;
      {lost_seen, op_res} = 4'h0;
      t_reset(1'b1);
      t_flags;
      t_ignore;
      t_cfg(OP_CFG_P264, 1'b0);
      t_cfg(OP_CFG_P256, 1'b1);
      t_deep;
      t_ultra;
      t_reset(1'b0);
      results;
   end

   // Watchdog
   initial begin
      #2000000;
      error_cnt++;
      results;
   end
endmodule

bind fpmsc_ctrl fpmsc_ctrl_checker fpmsc_ctrl_checker_inst (.clk(clk), .rst_n(rst_n),
   .cs_n(cs_n), .miso_oe(miso_oe), .array_busy(array_busy), .page256(page256),
   .nv_write(nv_write), .standby(standby), .deep_pd(deep_pd), .ultra_pd(ultra_pd),
   .buffer_lost(buffer_lost));
